// *** ttc_pkg.sv ***
package ttc_pkg;

  // Register byte addresses
  localparam logic [7:0] TTC_ADDR_MODE  = 8'h00;
  localparam logic [7:0] TTC_ADDR_CTRL  = 8'h04;
  localparam logic [7:0] TTC_ADDR_CLKC  = 8'h08;
  localparam logic [7:0] TTC_ADDR_CNT0  = 8'h0c;
  localparam logic [7:0] TTC_ADDR_CNT1  = 8'h10;
  localparam logic [7:0] TTC_ADDR_CTL2  = 8'h14;
  localparam logic [7:0] TTC_ADDR_MOD2  = 8'h18;
  localparam logic [7:0] TTC_ADDR_CNT2  = 8'h1c;
  localparam logic [7:0] TTC_ADDR_CAP   = 8'h20;

  // Counter mode register fields
  localparam int TTC_MODE0_LSB = 0;
  localparam int TTC_FUNC0     = 2;
  localparam int TTC_GATE0     = 3;
  localparam int TTC_MODE1_LSB = 4;
  localparam int TTC_FUNC1     = 6;
  localparam int TTC_GATE1     = 7;

  // Counter control register fields
  localparam int TTC_RUN0 = 0;
  localparam int TTC_RUN1 = 1;
  localparam int TTC_OVF0 = 2;
  localparam int TTC_OVF1 = 3;

  // Clock control register fields
  localparam int TTC_TURBO0 = 0;
  localparam int TTC_TURBO1 = 1;
  localparam int TTC_TURBO2 = 2;

  // Third counter control and mode fields
  localparam int TTC_CPRL  = 0;
  localparam int TTC_FUNC2 = 1;
  localparam int TTC_RUN2  = 2;
  localparam int TTC_EXEN  = 3;
  localparam int TTC_OVF2  = 4;
  localparam int TTC_EXF   = 5;
  localparam int TTC_DIRECTION_ENABLE_BIT  = 0;
  localparam int TTC_ACLR  = 3;

  // Bits stored as written; flags are handled apart
  localparam logic [7:0] TTC_CTRL_RW = 8'h03;
  localparam logic [7:0] TTC_CLKC_RW = 8'h07;
  localparam logic [7:0] TTC_CTL2_RW = 8'h0f;
  localparam logic [7:0] TTC_MOD2_RW = 8'h09;

  // Operating modes of the first two counters
  localparam logic [1:0] TTC_M13   = 2'h0;
  localparam logic [1:0] TTC_M16   = 2'h1;
  localparam logic [1:0] TTC_M8R   = 2'h2;
  localparam logic [1:0] TTC_MSPLT = 2'h3;

  // Last machine cycle of the divide-by-three prescale
  localparam logic [1:0] TTC_MC_LAST = 2'h2;

  typedef enum logic [3:0] {
    TTC_C1 = 4'h1,
    TTC_C2 = 4'h2,
    TTC_C3 = 4'h4,
    TTC_C4 = 4'h8
  } ttc_phase_t;

  typedef struct packed {
    ttc_phase_t  phase;
    logic [1:0]  mc;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [3:0]  samp;
    logic [3:0]  edge_seen;
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    logic [7:0]  clkc;
    logic [7:0]  ctl2;
    logic [7:0]  mod2;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] cap;
    logic        req2;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ttc_state_t;

  localparam ttc_state_t TTC_STATE_RESET = '{phase: TTC_C1, default: '0};

endpackage

// *** ttc_top.sv ***
`timescale 1ns/1ns
// Contract
// (R1) Timers tick at clock/12, or clock/4 turbo
// (R2) Count pins sampled at C4, high-low is edge
// (R3) Count updates at C3 of next cycle
// (R4) Mode bits pick function and mode
// (R5) Mode 0 is 13-bit, low 5 bits
// (R6) Mode 0 low carry bumps high, wrap flags
// (R7) Count needs run and gate or pin high
// (R8) Mode 1 full 16-bit, wrap sets flag
// (R9) Mode 2 low reloads from high, flag
// (R10) Second counter frozen in mode 3
// (R11) First mode 3 splits into two bytes
// (R12) Second counter loses run and flag then
// (R13) Third counter pin or divided clock, run
// (R14) Capture mode counts up, wrap flags
// (R15) Trigger edge captures count, sets flag
// (R16) Auto-clear resets count after capture
// (R17) Up reload mode reloads on wrap
// (R18) Trigger edge forces reload, sets flag
// (R19) Up/down mode follows trigger pin level
// (R20) Trigger low counts down
// (R21) Up/down reloads both ways, flag set
// (R22) Up/down reload toggles flag, no request
module ttc_top
  import ttc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        first_count_input_pin_in,
  input  wire logic        second_count_input_pin_in,
  input  wire logic        third_count_input_pin_in,
  input  wire logic        trigger_input_pin_in,
  input  wire logic        first_interrupt_pin_in,
  input  wire logic        second_interrupt_pin_in,
  output logic             first_overflow_flag_out,
  output logic             second_overflow_flag_out,
  output logic             third_overflow_flag_out,
  output logic             external_event_flag_out,
  output logic             third_request_out
);

  ttc_state_t  s;
  ttc_state_t  n;
  logic        upd;
  logic        slow;
  logic        wr;
  logic [1:0]  m0;
  logic [1:0]  m1;
  logic        en0;
  logic        en1;
  logic        tick0;
  logic        tick1;
  logic        tick2;
  logic        trig;
  logic        updn;
  logic [16:0] st0;
  logic [16:0] st1;
  logic        set0;
  logic        set1;
  logic        set2;
  logic        setx;
  logic        togx;
  logic        clr0;
  logic        clr1;
  logic        clr2;
  logic        clrx;

  // One increment of a first or second counter; bit 16 is overflow
  function automatic logic [16:0] ttc_step(input logic [1:0] m, input logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = v[7:0];
    hi = v[15:8];
    case (m)
      TTC_M13: begin
        if (lo[4:0] == 5'h1f) begin
          ttc_step = {hi == 8'hff, hi + 8'h01, lo[7:5], 5'h00}; // (R5) (R6)
        end else begin
          ttc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01}; // (R5)
        end
      end
      TTC_M16: ttc_step = {v == 16'hffff, v + 16'h0001}; // (R8)
      TTC_M8R: begin
        if (lo == 8'hff) begin
          ttc_step = {1'b1, hi, hi}; // (R9)
        end else begin
          ttc_step = {1'b0, hi, lo + 8'h01}; // (R9)
        end
      end
      default: ttc_step = {lo == 8'hff, hi, lo + 8'h01}; // (R11)
    endcase
  endfunction

  assign m0 = s.mode[TTC_MODE0_LSB +: 2]; // (R4)
  assign m1 = s.mode[TTC_MODE1_LSB +: 2]; // (R4)

  always_comb begin
    n     = s;
    upd   = 1'b0;
    slow  = 1'b0;
    wr    = 1'b0;
    en0   = 1'b0;
    en1   = 1'b0;
    tick0 = 1'b0;
    tick1 = 1'b0;
    tick2 = 1'b0;
    trig  = 1'b0;
    updn  = 1'b0;
    st0   = {1'b0, s.cnt0};
    st1   = {1'b0, s.cnt1};
    set0  = 1'b0;
    set1  = 1'b0;
    set2  = 1'b0;
    setx  = 1'b0;
    togx  = 1'b0;

    // Pins pass two flops before anything reads them
    n.sync1 = {second_interrupt_pin_in, first_interrupt_pin_in, trigger_input_pin_in,
               third_count_input_pin_in, second_count_input_pin_in,
               first_count_input_pin_in};
    n.sync2 = s.sync1;

    // Machine cycle of four phases
    unique case (s.phase)
      TTC_C1: n.phase = TTC_C2;
      TTC_C2: n.phase = TTC_C3;
      TTC_C3: n.phase = TTC_C4;
      TTC_C4: n.phase = TTC_C1;
    endcase

    if (s.phase == TTC_C4) begin
      n.samp      = s.sync2[3:0]; // (R2)
      n.edge_seen = s.samp & ~s.sync2[3:0]; // (R2)
      n.mc        = (s.mc == TTC_MC_LAST) ? 2'h0 : s.mc + 2'h1; // (R1)
    end

    // Edges caught at C4 act at the next C3, so they cost one machine cycle
    upd  = (s.phase == TTC_C3); // (R3)
    slow = (s.mc == TTC_MC_LAST);

    // First counter
    tick0 = upd & (s.mode[TTC_FUNC0] ? s.edge_seen[0]
                                      : (s.clkc[TTC_TURBO0] | slow)); // (R1) (R4)
    en0   = s.ctrl[TTC_RUN0] & (~s.mode[TTC_GATE0] | s.sync2[4]); // (R7)
    if (tick0 & en0) begin
      st0    = ttc_step(m0, s.cnt0);
      n.cnt0 = st0[15:0];
      set0   = st0[16];
    end
    // Split mode high byte is a plain timer run by the second run bit
    if (m0 == TTC_MSPLT && upd && (s.clkc[TTC_TURBO0] | slow) && s.ctrl[TTC_RUN1]) begin
      n.cnt0[15:8] = s.cnt0[15:8] + 8'h01; // (R11)
      set1         = (s.cnt0[15:8] == 8'hff); // (R11)
    end

    // Second counter
    tick1 = upd & (s.mode[TTC_FUNC1] ? s.edge_seen[1]
                                      : (s.clkc[TTC_TURBO1] | slow)); // (R1) (R4)
    en1   = ((m0 == TTC_MSPLT) | s.ctrl[TTC_RUN1])
            & (~s.mode[TTC_GATE1] | s.sync2[5]); // (R7) (R12)
    if (tick1 & en1 & (m1 != TTC_MSPLT)) begin // (R10) (R12)
      st1    = ttc_step(m1, s.cnt1);
      n.cnt1 = st1[15:0];
      set1   = set1 | (st1[16] & (m0 != TTC_MSPLT)); // (R12)
    end

    // Third counter
    tick2 = upd & s.ctl2[TTC_RUN2]
            & (s.ctl2[TTC_FUNC2] ? s.edge_seen[2]
                                 : (s.clkc[TTC_TURBO2] | slow)); // (R13)
    trig  = upd & s.edge_seen[3] & s.ctl2[TTC_EXEN];
    updn  = ~s.ctl2[TTC_CPRL] & s.mod2[TTC_DIRECTION_ENABLE_BIT];
    if (s.ctl2[TTC_CPRL]) begin
      if (tick2) begin
        n.cnt2 = s.cnt2 + 16'h0001; // (R14)
        set2   = (s.cnt2 == 16'hffff); // (R14)
      end
      if (trig) begin
        n.cap = s.cnt2; // (R15)
        setx  = 1'b1; // (R15)
        if (s.mod2[TTC_ACLR]) begin
          n.cnt2 = 16'h0000; // (R16)
        end
      end
    end else if (!updn) begin
      if (tick2) begin
        if (s.cnt2 == 16'hffff) begin
          n.cnt2 = s.cap; // (R17)
          set2   = 1'b1; // (R17)
        end else begin
          n.cnt2 = s.cnt2 + 16'h0001; // (R17)
        end
      end
      if (trig) begin
        n.cnt2 = s.cap; // (R18)
        setx   = 1'b1; // (R18)
      end
    end else if (tick2) begin
      if (s.sync2[3]) begin
        if (s.cnt2 == 16'hffff) begin
          n.cnt2 = s.cap; // (R21)
          set2   = 1'b1; // (R21)
          togx   = 1'b1; // (R22)
        end else begin
          n.cnt2 = s.cnt2 + 16'h0001; // (R19)
        end
      end else begin
        if (s.cnt2 == s.cap) begin
          n.cnt2 = 16'hffff; // (R21)
          set2   = 1'b1; // (R21)
          togx   = 1'b1; // (R22)
        end else begin
          n.cnt2 = s.cnt2 - 16'h0001; // (R20)
        end
      end
    end

    // APB slave: one wait state, then the access completes
    n.pready = psel_in & penable_in & ~s.pready;
    wr       = psel_in & penable_in & s.pready & pwrite_in;
    if (psel_in & penable_in & ~s.pready) begin
      n.pslverr = 1'b0;
      case (paddr_in)
        TTC_ADDR_MODE: n.prdata = {24'h000000, s.mode};
        TTC_ADDR_CTRL: n.prdata = {24'h000000, s.ctrl};
        TTC_ADDR_CLKC: n.prdata = {24'h000000, s.clkc};
        TTC_ADDR_CNT0: n.prdata = {16'h0000, s.cnt0};
        TTC_ADDR_CNT1: n.prdata = {16'h0000, s.cnt1};
        TTC_ADDR_CTL2: n.prdata = {24'h000000, s.ctl2};
        TTC_ADDR_MOD2: n.prdata = {24'h000000, s.mod2};
        TTC_ADDR_CNT2: n.prdata = {16'h0000, s.cnt2};
        TTC_ADDR_CAP:  n.prdata = {16'h0000, s.cap};
        default: begin
          n.prdata  = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end else begin
      n.prdata  = 32'h00000000;
      n.pslverr = 1'b0;
    end

    // Software writes win over counting in the same cycle
    if (wr) begin
      case (paddr_in)
        TTC_ADDR_MODE: n.mode = pwdata_in[7:0];
        TTC_ADDR_CTRL: n.ctrl = pwdata_in[7:0] & TTC_CTRL_RW;
        TTC_ADDR_CLKC: n.clkc = pwdata_in[7:0] & TTC_CLKC_RW;
        TTC_ADDR_CNT0: n.cnt0 = pwdata_in[15:0];
        TTC_ADDR_CNT1: n.cnt1 = pwdata_in[15:0];
        TTC_ADDR_CTL2: n.ctl2 = pwdata_in[7:0] & TTC_CTL2_RW;
        TTC_ADDR_MOD2: n.mod2 = pwdata_in[7:0] & TTC_MOD2_RW;
        TTC_ADDR_CNT2: n.cnt2 = pwdata_in[15:0];
        TTC_ADDR_CAP:  n.cap  = pwdata_in[15:0];
        default: n.mode = s.mode;
      endcase
    end

    // Flags clear on a written one; a hardware set in that cycle wins
    clr0 = wr & (paddr_in == TTC_ADDR_CTRL) & pwdata_in[TTC_OVF0];
    clr1 = wr & (paddr_in == TTC_ADDR_CTRL) & pwdata_in[TTC_OVF1];
    clr2 = wr & (paddr_in == TTC_ADDR_CTL2) & pwdata_in[TTC_OVF2];
    clrx = wr & (paddr_in == TTC_ADDR_CTL2) & pwdata_in[TTC_EXF];
    n.ctrl[TTC_OVF0] = (s.ctrl[TTC_OVF0] & ~clr0) | set0; // (R6) (R8) (R9)
    n.ctrl[TTC_OVF1] = (s.ctrl[TTC_OVF1] & ~clr1) | set1; // (R11)
    n.ctl2[TTC_OVF2] = (s.ctl2[TTC_OVF2] & ~clr2) | set2; // (R14) (R17) (R21)
    n.ctl2[TTC_EXF]  = ((s.ctl2[TTC_EXF] & ~clrx) | setx) ^ togx; // (R22)

    // Request for the third counter; external flag is muted in up/down mode
    n.req2 = n.ctl2[TTC_OVF2]
             | (n.ctl2[TTC_EXF] & ~(~n.ctl2[TTC_CPRL] & n.mod2[TTC_DIRECTION_ENABLE_BIT])); // (R14) (R15) (R22)
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      s <= TTC_STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign prdata_out               = s.prdata;
  assign pready_out               = s.pready;
  assign pslverr_out              = s.pslverr;
  assign first_overflow_flag_out  = s.ctrl[TTC_OVF0];
  assign second_overflow_flag_out = s.ctrl[TTC_OVF1];
  assign third_overflow_flag_out  = s.ctl2[TTC_OVF2];
  assign external_event_flag_out  = s.ctl2[TTC_EXF];
  assign third_request_out        = s.req2;

endmodule

// *** ttc_checker.sv ***
`timescale 1ns/1ns
module ttc_checker
  import ttc_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        first_overflow_flag_out,
  input wire logic        third_overflow_flag_out,
  input wire logic        external_event_flag_out,
  input wire logic        third_request_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  a_ready_wait: assert property (psel_in && penable_in && !$past(penable_in) |->
    !pready_out ##1 pready_out) else $error("ready not in second access cycle");
  a_err_unmapped: assert property (pready_out |->
    pslverr_out == (paddr_in > 8'h20 || paddr_in[1:0] != 2'h0)) else $error("bad slverr");
  a_data_quiet: assert property (!pready_out || pslverr_out |-> prdata_out == 32'h0)
    else $error("read data not quiet");
  a_req_ovf: assert property (third_overflow_flag_out |-> third_request_out)
    else $error("request missing");
  a_req_idle: assert property (!third_overflow_flag_out &&
    !external_event_flag_out |-> !third_request_out) else $error("stray request");
  a_ovf0_clear: assert property ($fell(first_overflow_flag_out) |-> $past(pready_out &&
    pwrite_in && paddr_in == TTC_ADDR_CTRL && pwdata_in[2])) else $error("flag lost");
  a_ovf2_clear: assert property ($fell(third_overflow_flag_out) |-> $past(pready_out &&
    pwrite_in && paddr_in == TTC_ADDR_CTL2 && pwdata_in[4])) else $error("flag2 lost");
endmodule
bind ttc_top ttc_checker u_chk (.clock_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .first_overflow_flag_out,
  .third_overflow_flag_out, .external_event_flag_out, .third_request_out);

// *** ttc_pin_model.sv ***
`timescale 1ns/1ns
module ttc_pin_model (
  input  wire logic       clock_in,
  input  wire logic       start_in,
  input  wire logic [3:0] pulses_in,
  input  wire logic [4:0] half_in,
  output logic            count_pin_out,
  output logic            busy_out
);
  logic [4:0] left_reg = 5'h0;
  logic [4:0] tick_reg = 5'h0;
  // Idles high so every frame starts with a real fall
  initial count_pin_out = 1'b1;
  assign busy_out = (left_reg != 5'h0);
  always @(posedge clock_in) begin
    if (start_in) begin
      left_reg <= {pulses_in, 1'b0};
      tick_reg <= half_in;
    end else if (busy_out && tick_reg == 5'h0) begin
      count_pin_out <= ~count_pin_out;
      left_reg <= left_reg - 5'h1;
      tick_reg <= half_in;
    end else if (busy_out) begin
      tick_reg <= tick_reg - 5'h1;
    end
  end
endmodule

// *** ttc_top_tb.sv ***
`timescale 1ns/1ns
module ttc_top_tb;
  import ttc_pkg::*;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        first_interrupt_pin = 1'b0;
  logic        trig = 1'b1;
  logic        pstart = 1'b0;
  logic [3:0]  pn = 4'h0;
  logic [4:0]  half = 5'h6;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, ovf0, ovf1, ovf2, exf, req, pin, pbusy;
  logic [32:0] exp_q[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          seed = 75;
  int          i;
  logic [7:0]  tm[9] = '{8'h30, 8'h31, 8'h31, 8'h32, 8'h39, 8'h35, 8'h35, 8'h31, 8'h39};
  logic [15:0] ld[9] = '{16'hff38, 16'hff38, 16'hfff8, 16'hf0f8, 16'hfff8, 16'hfffe, 16'hfffe,
                         16'hfff4, 16'hfff8};
  logic [35:0] np = 36'h001200000;
  logic [8:0]  ov = 9'b100101101;
  ttc_top u_dut (.clock_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .first_count_input_pin_in(pin),
    .second_count_input_pin_in(pin), .third_count_input_pin_in(pin), .trigger_input_pin_in(trig),
    .first_interrupt_pin_in(first_interrupt_pin), .second_interrupt_pin_in(first_interrupt_pin), .first_overflow_flag_out(ovf0),
    .second_overflow_flag_out(ovf1), .third_overflow_flag_out(ovf2),
    .external_event_flag_out(exf), .third_request_out(req));
  ttc_pin_model u_pins (.clock_in, .start_in(pstart), .pulses_in(pn), .half_in(half),
    .count_pin_out(pin), .busy_out(pbusy));
  initial forever #10 clock_in = ~clock_in;
  task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
    check_count++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Random pulse width; never below one machine cycle plus sync
  task automatic pulse(input logic [3:0] n);
    int k;
    k = 0;
    half <= 5'(6 + ($random(seed) & 7));
    pn <= n;
    pstart <= 1'b1;
    @(posedge clock_in);
    pstart <= 1'b0;
    @(posedge clock_in);
    while (pbusy && k < 400) begin
      @(posedge clock_in);
      k++;
    end
    repeat (16) @(posedge clock_in);
  endtask
  task automatic fall();
    trig <= 1'b0;
    repeat (12) @(posedge clock_in);
    trig <= 1'b1;
    repeat (12) @(posedge clock_in);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (pready_out === 1'b1 && pwrite_in === 1'b0) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1);
      else chk({pslverr_out, prdata_out}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(TTC_ADDR_MODE, 33'h0);
    rd(8'h24, 33'h100000000);
    wr(TTC_ADDR_CNT1, 32'h1234);
    $display("reset test done");
    for (i = 0; i < 9; i++) begin
      first_interrupt_pin <= (i == 8);
      wr(TTC_ADDR_CTRL, 32'h0c);
      wr(TTC_ADDR_MODE, {24'h0, tm[i]});
      wr(TTC_ADDR_CLKC, {31'h0, i != 7});
      wr(TTC_ADDR_CNT0, {16'h0, ld[i]});
      wr(TTC_ADDR_CTRL, 32'h03);
      pulse(np[4*i +: 4]);
      repeat (60) @(posedge clock_in);
      wr(TTC_ADDR_CTRL, 32'h00);
      rd(TTC_ADDR_CTRL, {30'h0, ov[i], 2'h0});
      rd(TTC_ADDR_CNT1, 33'h1234);
    end
    // Split mode; a window of 80 clocks holds exactly 20 turbo ticks
    first_interrupt_pin <= 1'b0;
    wr(TTC_ADDR_CTRL, 32'h0c);
    wr(TTC_ADDR_MODE, 32'h9b);
    wr(TTC_ADDR_CLKC, 32'h03);
    wr(TTC_ADDR_CNT0, 32'hf0f0);
    wr(TTC_ADDR_CNT1, 32'hfff0);
    wr(TTC_ADDR_CTRL, 32'h01);
    first_interrupt_pin <= 1'b1;
    repeat (80) @(posedge clock_in);
    first_interrupt_pin <= 1'b0;
    repeat (8) @(posedge clock_in);
    rd(TTC_ADDR_CNT1, 33'h0004);
    rd(TTC_ADDR_CNT0, 33'hf004);
    rd(TTC_ADDR_CTRL, 33'h05);
    wr(TTC_ADDR_CTRL, 32'h02);
    repeat (76) @(posedge clock_in);
    wr(TTC_ADDR_CTRL, 32'h00);
    rd(TTC_ADDR_CTRL, 33'h0c);
    rd(TTC_ADDR_CNT0, 33'h0404);
    $display("first counters test done");
    wr(TTC_ADDR_MOD2, 32'h08);
    wr(TTC_ADDR_CNT2, 32'h0100);
    wr(TTC_ADDR_CTL2, 32'h0f);
    fall();
    rd(TTC_ADDR_CAP, 33'h0100);
    rd(TTC_ADDR_CNT2, 33'h0);
    chk({32'h0, req}, 33'h1);
    rd(TTC_ADDR_CTL2, 33'h2f);
    wr(TTC_ADDR_CTL2, 32'h3f);
    wr(TTC_ADDR_CNT2, 32'hfffe);
    pulse(4'h2);
    rd(TTC_ADDR_CTL2, 33'h1f);
    wr(TTC_ADDR_MOD2, 32'h00);
    wr(TTC_ADDR_CTL2, 32'h3e);
    fall();
    rd(TTC_ADDR_CNT2, 33'h0100);
    wr(TTC_ADDR_CNT2, 32'hfffe);
    pulse(4'h2);
    rd(TTC_ADDR_CNT2, 33'h0100);
    rd(TTC_ADDR_CTL2, 33'h3e);
    wr(TTC_ADDR_MOD2, 32'h01);
    wr(TTC_ADDR_CTL2, 32'h36);
    trig <= 1'b0;
    wr(TTC_ADDR_CNT2, 32'h0102);
    pulse(4'h3);
    rd(TTC_ADDR_CNT2, 33'hffff);
    rd(TTC_ADDR_CTL2, 33'h36);
    wr(TTC_ADDR_CTL2, 32'h16);
    repeat (3) @(posedge clock_in);
    chk({32'h0, req}, 33'h0);
    trig <= 1'b1;
    wr(TTC_ADDR_CNT2, 32'hfffe);
    pulse(4'h2);
    rd(TTC_ADDR_CTL2, 33'h16);
    // Divided clock for the third counter, same exact window
    wr(TTC_ADDR_CLKC, 32'h04);
    wr(TTC_ADDR_CNT2, 32'hfff0);
    wr(TTC_ADDR_CTL2, 32'h35);
    repeat (76) @(posedge clock_in);
    wr(TTC_ADDR_CTL2, 32'h01);
    rd(TTC_ADDR_CNT2, 33'h0004);
    rd(TTC_ADDR_CTL2, 33'h11);
    $display("third counter test done");
    end_sim();
  end
endmodule
